// file: logic/uifc_defs.vh
// constants for the serial port interrupt and fifo control block
`ifndef UIFC_DEFS_VH
`define UIFC_DEFS_VH
`define UIFC_ADDR_RX_DATA 3'h0
`define UIFC_ADDR_MASK 3'h1
`define UIFC_ADDR_SOURCE 3'h2
`define UIFC_ADDR_LINE 3'h5
`define UIFC_ADDR_MODEM 3'h6
`define UIFC_MASK_RX 0
`define UIFC_MASK_TX 1
`define UIFC_MASK_LINE 2
`define UIFC_MASK_MODEM 3
`define UIFC_MASK_SPECIAL 5
`define UIFC_MASK_WMASK 8'h2F
`define UIFC_SETUP_EN 0
`define UIFC_SETUP_RXRST 1
`define UIFC_SETUP_TXRST 2
`define UIFC_SETUP_DMA 3
`define UIFC_CODE_LINE 4'h6
`define UIFC_CODE_TIMEOUT 4'hC
`define UIFC_CODE_RX 4'h4
`define UIFC_CODE_TX 4'h2
`define UIFC_CODE_MODEM 4'h0
`define UIFC_CODE_NONE 4'h1
`define UIFC_TO_CHARS 4
`define UIFC_TO_BITS 12
`define UIFC_BITS_PER_CHAR 10
`define UIFC_TRIG_SEL0 1
`define UIFC_TRIG_SEL1 4
`define UIFC_TRIG_SEL2 8
`define UIFC_TRIG_SEL3 14
`define UIFC_LINE_RESET 8'h60
`define UIFC_SOURCE_RESET 8'h01
`endif

// file: logic/uifc_top.v
// interrupt mask, prioritised interrupt source and fifo setup of a serial port
`timescale 1ns/1ns
`include "uifc_defs.vh"
module uifc_top #(
  parameter LEVEL_W = 5
)
(
  input wire core_clk_in,
  input wire resetn_in,
  input wire [2:0] addr_in,
  input wire rd_in,
  input wire wr_in,
  input wire [7:0] wdata_in,
  input wire rx_push_in,
  input wire rx_pop_in,
  input wire [LEVEL_W-1:0] rx_level_in,
  input wire [LEVEL_W-1:0] tx_level_in,
  input wire tx_load_in,
  input wire tx_shifter_empty_in,
  input wire rx_overrun_in,
  input wire [2:0] head_error_in,
  input wire fifo_error_in,
  input wire [3:0] modem_delta_in,
  input wire bit_tick_in,
  input wire [7:0] modem_control_in,
  output reg [7:0] rdata_out,
  output reg irq_out,
  output reg [7:0] line_state_out,
  output reg rx_fifo_reset_out,
  output reg tx_fifo_reset_out,
  output reg fifo_enable_out,
  output reg dma_mode_out,
  output reg special_mode_out,
  output reg soft_reset_out,
  output reg power_down_out,
  output reg tx_request_pin_out,
  output reg rx_request_pin_out
);
  // idle span in bit times, held at the width of the counter
  localparam [7:0] TO_BITS = `UIFC_TO_CHARS * `UIFC_BITS_PER_CHAR + `UIFC_TO_BITS;
  reg [7:0] interrupt_mask;
  reg [7:0] fifo_setup;
  reg rx_avail;
  reg line_pend;
  reg modem_pend;
  reg tx_pend;
  reg timeout_pend;
  reg [7:0] to_count;
  reg [LEVEL_W-1:0] rx_trig;
  reg [LEVEL_W-1:0] tx_trig;
  reg [3:0] code;
  reg any_pend;
  reg [7:0] next_rdata;
  wire rd_line;
  wire rd_modem;
  wire rd_source;
  wire wr_mask;
  wire wr_setup;
  wire tx_empty;
  wire tx_ready;
  wire rx_ready;
  wire setup_ok;
  wire rx_some;
  wire line_set;
  wire tx_arm;
  wire to_expire;
  wire [1:0] rx_sel;
  wire [1:0] tx_sel;
  wire [7:0] line_word_now;
  wire [7:0] source_word;

  // trigger depth from a two-bit select; LEVEL_W must hold the largest depth
  function [LEVEL_W-1:0] trig_level;
    input [1:0] sel;
    reg [31:0] depth;
    begin
      case (sel)
        2'b00: depth = `UIFC_TRIG_SEL0;
        2'b01: depth = `UIFC_TRIG_SEL1;
        2'b10: depth = `UIFC_TRIG_SEL2;
        default: depth = `UIFC_TRIG_SEL3;
      endcase
      trig_level = depth[LEVEL_W-1:0];
    end
  endfunction

  // line state word, shared by the output copy and the register read
  function [7:0] line_word;
    input fifo_err;
    input tx_none;
    input shift_none;
    input [2:0] head_err;
    input overrun;
    input rx_any;
    begin
      line_word = {fifo_err, tx_none && shift_none, tx_none, head_err, overrun, rx_any};
    end
  endfunction

  assign rd_line = rd_in && addr_in == `UIFC_ADDR_LINE;
  assign rd_modem = rd_in && addr_in == `UIFC_ADDR_MODEM;
  assign rd_source = rd_in && addr_in == `UIFC_ADDR_SOURCE;
  assign wr_mask = wr_in && addr_in == `UIFC_ADDR_MASK;
  assign wr_setup = wr_in && addr_in == `UIFC_ADDR_SOURCE;
  assign setup_ok = wdata_in[`UIFC_SETUP_EN];
  assign tx_empty = tx_level_in == {LEVEL_W{1'b0}};
  assign rx_some = rx_level_in != {LEVEL_W{1'b0}};
  // overrun flags at once; the head errors only as the head byte leaves; the fifo error never flags
  assign line_set = rx_overrun_in || (rx_pop_in && |head_error_in);
  // arming the mask while the holding register is empty fires at once
  assign tx_arm = wr_mask && wdata_in[`UIFC_MASK_TX] && !interrupt_mask[`UIFC_MASK_TX]
    && tx_empty;
  assign to_expire = bit_tick_in && to_count == TO_BITS - 8'h01;
  assign rx_sel = fifo_setup[7:6];
  assign tx_sel = fifo_setup[5:4];
  assign line_word_now = line_word(fifo_error_in, tx_empty, tx_shifter_empty_in,
    head_error_in, rx_overrun_in, rx_some);
  assign source_word = {{2{fifo_setup[`UIFC_SETUP_EN]}},
    interrupt_mask[`UIFC_MASK_SPECIAL] && !rx_ready,
    interrupt_mask[`UIFC_MASK_SPECIAL] && !tx_ready,
    code};

  // without the fifo a single character is the trigger
  always @*
  begin
    rx_trig = trig_level(2'b00);
    if (fifo_setup[`UIFC_SETUP_EN])
      rx_trig = trig_level(rx_sel);
  end

  // transmit trigger select is honoured only in special mode
  always @*
  begin
    tx_trig = trig_level(2'b00);
    if (interrupt_mask[`UIFC_MASK_SPECIAL])
      tx_trig = trig_level(tx_sel);
  end

  // read data follows the address every cycle; unlisted addresses read zero
  always @*
  begin
    next_rdata = 8'h00;
    case (addr_in)
      `UIFC_ADDR_MASK: next_rdata = interrupt_mask;
      `UIFC_ADDR_SOURCE: next_rdata = source_word;
      `UIFC_ADDR_LINE: next_rdata = line_word_now;
      default: next_rdata = 8'h00;
    endcase
  end

  // receive interrupt level condition: one char without fifo, trigger with
  assign rx_ready = rx_level_in >= rx_trig;
  assign tx_ready = fifo_setup[`UIFC_SETUP_EN] ? (tx_level_in < tx_trig) : tx_empty;

  always @*
  begin
    any_pend = 1'b1;
    // one code at a time; lower sources stay queued in their own flags
    if (line_pend && interrupt_mask[`UIFC_MASK_LINE])
      code = `UIFC_CODE_LINE;
    else if (timeout_pend && interrupt_mask[`UIFC_MASK_RX])
      code = `UIFC_CODE_TIMEOUT;
    else if (rx_avail && interrupt_mask[`UIFC_MASK_RX])
      code = `UIFC_CODE_RX;
    else if (tx_pend && interrupt_mask[`UIFC_MASK_TX])
      code = `UIFC_CODE_TX;
    else if (modem_pend && interrupt_mask[`UIFC_MASK_MODEM])
      code = `UIFC_CODE_MODEM;
    else
    begin
      code = `UIFC_CODE_NONE;
      any_pend = 1'b0;
    end
  end

  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      interrupt_mask <= 8'h00;
      fifo_setup <= 8'h00;
      rx_fifo_reset_out <= 1'b0;
      tx_fifo_reset_out <= 1'b0;
    end
    else
    begin
      rx_fifo_reset_out <= 1'b0;
      tx_fifo_reset_out <= 1'b0;
      if (wr_mask)
        interrupt_mask <= wdata_in & `UIFC_MASK_WMASK;
      if (wr_setup)
      begin
        if (setup_ok)
        begin
          fifo_setup <= {wdata_in[7:3], 3'b001};
          rx_fifo_reset_out <= wdata_in[`UIFC_SETUP_RXRST];
          tx_fifo_reset_out <= wdata_in[`UIFC_SETUP_TXRST];
        end
        else
          fifo_setup <= 8'h00;
      end
    end
  end

  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rx_avail <= 1'b0;
      line_pend <= 1'b0;
      modem_pend <= 1'b0;
      tx_pend <= 1'b0;
      timeout_pend <= 1'b0;
      to_count <= 8'h00;
    end
    else
    begin
      rx_avail <= rx_ready;
      // set wins over the read that clears it
      if (line_set)
        line_pend <= 1'b1;
      else if (rd_line)
        line_pend <= 1'b0;
      if (|modem_delta_in)
        modem_pend <= 1'b1;
      else if (rd_modem)
        modem_pend <= 1'b0;
      if (tx_load_in)
        tx_pend <= 1'b0;
      else if (tx_arm)
        tx_pend <= 1'b1;
      else if (tx_ready && !tx_pend && !interrupt_mask[`UIFC_MASK_TX])
        tx_pend <= 1'b1;
      else if (rd_source && !interrupt_mask[`UIFC_MASK_TX])
        tx_pend <= 1'b0;
      else if (tx_ready && interrupt_mask[`UIFC_MASK_TX])
        tx_pend <= 1'b1;
      // idle timer: restarts on any receive fifo push or pop
      if (!rx_some)
      begin
        timeout_pend <= 1'b0;
        to_count <= 8'h00;
      end
      else if (rx_push_in || rx_pop_in)
        to_count <= 8'h00;
      else if (bit_tick_in && to_count < TO_BITS)
      begin
        to_count <= to_count + 8'h01;
        // the timeout exists only with the fifo on
        if (to_expire && fifo_setup[`UIFC_SETUP_EN])
          timeout_pend <= 1'b1;
      end
    end
  end

  always @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rdata_out <= `UIFC_SOURCE_RESET;
      irq_out <= 1'b0;
      line_state_out <= `UIFC_LINE_RESET;
      fifo_enable_out <= 1'b0;
      dma_mode_out <= 1'b0;
      special_mode_out <= 1'b0;
      soft_reset_out <= 1'b0;
      power_down_out <= 1'b0;
      tx_request_pin_out <= 1'b1;
      rx_request_pin_out <= 1'b1;
    end
    else
    begin
      irq_out <= any_pend;
      line_state_out <= line_word_now;
      fifo_enable_out <= fifo_setup[`UIFC_SETUP_EN];
      dma_mode_out <= fifo_setup[`UIFC_SETUP_DMA];
      special_mode_out <= interrupt_mask[`UIFC_MASK_SPECIAL];
      soft_reset_out <= interrupt_mask[`UIFC_MASK_SPECIAL] && modem_control_in[2];
      power_down_out <= interrupt_mask[`UIFC_MASK_SPECIAL] && modem_control_in[7];
      // dma mode holds requests to trigger level, normal mode to single char
      tx_request_pin_out <= fifo_setup[`UIFC_SETUP_DMA] ? !tx_ready : !tx_empty;
      rx_request_pin_out <= fifo_setup[`UIFC_SETUP_DMA] ?
        !(rx_ready || timeout_pend) : !rx_some;
      rdata_out <= next_rdata;
    end
  end
endmodule // uifc_top

// file: testbench/uifc_host.sv
// host model of the byte-wide register port
`timescale 1ns/1ns
module uifc_host (
  input wire core_clk_in,
  input wire [7:0] rdata_in,
  output logic [2:0] addr_out = 3'h0,
  output logic rd_out = 1'b0,
  output logic wr_out = 1'b0,
  output logic [7:0] wdata_out = 8'h00
);
  // setup writes carry bit 0 high except where a test means otherwise
  task wr(input [2:0] a, input [7:0] v);
    @(negedge core_clk_in);
    addr_out = a;
    wdata_out = v;
    wr_out = 1'b1;
    @(negedge core_clk_in);
    wr_out = 1'b0;
    wdata_out = ~v;
  endtask
  // polled access: status is read back, never assumed
  task rd(input [2:0] a, output [7:0] v);
    @(negedge core_clk_in);
    addr_out = a;
    rd_out = 1'b1;
    @(negedge core_clk_in);
    rd_out = 1'b0;
    v = rdata_in;
  endtask
endmodule // uifc_host

// file: testbench/uifc_monitor.sv
// port assertions for the interrupt and fifo control block
`timescale 1ns/1ns
module uifc_monitor (
  input wire core_clk_in,
  input wire resetn_in,
  input wire [2:0] addr_in,
  input wire rd_in,
  input wire wr_in,
  input wire [7:0] wdata_in,
  input wire [7:0] rdata_out,
  input wire rx_fifo_reset_out,
  input wire tx_fifo_reset_out,
  input wire fifo_enable_out,
  input wire dma_mode_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  wire set_wr = wr_in && addr_in == 3'h2;
  wire src_rd = rd_in && !wr_in && addr_in == 3'h2;
  reset_pulse_a: assert property (rx_fifo_reset_out && !set_wr |=> !rx_fifo_reset_out)
    else $error("rx reset held");
  rx_reset_a: assert property (set_wr && wdata_in[0] && wdata_in[1] |=> rx_fifo_reset_out)
    else $error("rx reset missing");
  setup_gate_a: assert property (set_wr && !wdata_in[0] |=> !tx_fifo_reset_out ##1 !dma_mode_out)
    else $error("setup not gated");
  fifo_enable_a: assert property (set_wr |-> ##2 fifo_enable_out == $past(wdata_in[0], 2))
    else $error("enable wrong");
  dma_select_a: assert property (set_wr && wdata_in[0] |-> ##2 dma_mode_out == $past(wdata_in[3], 2))
    else $error("dma wrong");
  source_code_a: assert property (src_rd |=> rdata_out[3:0] inside {4'h6, 4'hC, 4'h4, 4'h2, 4'h0, 4'h1})
    else $error("bad code");
  source_fifo_a: assert property (src_rd |=> rdata_out[7:6] == {2{$past(fifo_enable_out)}})
    else $error("fifo bits wrong");
  mask_reserved_a: assert property (rd_in && addr_in == 3'h1 |=> rdata_out[7:6] == 2'h0 && !rdata_out[4])
    else $error("mask reserved set");
endmodule // uifc_monitor
bind uifc_top uifc_monitor mon (.core_clk_in, .resetn_in, .addr_in, .rd_in, .wr_in, .wdata_in,
  .rdata_out, .rx_fifo_reset_out, .tx_fifo_reset_out, .fifo_enable_out, .dma_mode_out);

// file: testbench/uifc_top_test.sv
// self-checking bench for the interrupt and fifo control block
`timescale 1ns/1ns
module uifc_top_test;
  logic core_clk_in = 0, resetn_in = 0, rx_pop_in = 0, tx_load_in = 0, rx_overrun_in = 0;
  logic bit_tick_in = 0, rd_in, wr_in, irq_out, rx_fifo_reset_out, tx_fifo_reset_out;
  logic fifo_enable_out, dma_mode_out, special_mode_out, soft_reset_out, power_down_out;
  logic tx_request_pin_out, rx_request_pin_out;
  logic [2:0] addr_in;
  logic [7:0] wdata_in, rdata_out, line_state_out, d;
  logic [4:0] rx_level_in = 0, tx_level_in = 0;
  logic [3:0] modem_delta_in = 0;
  logic rx_push_in = 1'b0, tx_shifter_empty_in = 1'b1, fifo_error_in = 1'b0;
  logic [2:0] head_error_in = 3'h0;
  logic [7:0] modem_control_in = 8'h00;
  int miscompares = 0, n_tests = 0;
  always #10 core_clk_in = ~core_clk_in;
  // one tick every second cycle keeps the timeout short
  always @(negedge core_clk_in) bit_tick_in <= ~bit_tick_in;
  uifc_top dut (.core_clk_in, .resetn_in, .addr_in, .rd_in, .wr_in, .wdata_in, .rx_push_in,
    .rx_pop_in, .rx_level_in, .tx_level_in, .tx_load_in, .tx_shifter_empty_in, .rx_overrun_in,
    .head_error_in, .fifo_error_in, .modem_delta_in, .bit_tick_in, .modem_control_in,
    .rdata_out, .irq_out, .line_state_out, .rx_fifo_reset_out, .tx_fifo_reset_out,
    .fifo_enable_out, .dma_mode_out, .special_mode_out, .soft_reset_out, .power_down_out,
    .tx_request_pin_out, .rx_request_pin_out);
  uifc_host host (.core_clk_in, .rdata_in(rdata_out), .addr_out(addr_in), .rd_out(rd_in),
    .wr_out(wr_in), .wdata_out(wdata_in));
  task chk(input [7:0] got, input [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task rchk(input [2:0] a, input [7:0] e);
    host.rd(a, d);
    chk(d, e);
  endtask
  task t_setup;
    chk(line_state_out, 8'h60);
    rchk(3'h1, 8'h00);
    rchk(3'h2, 8'h01);
    host.wr(3'h2, 8'h0F);
    chk({6'h0, rx_fifo_reset_out, tx_fifo_reset_out}, 8'h03);
    @(negedge core_clk_in);
    chk({6'h0, fifo_enable_out, dma_mode_out}, 8'h03);
    chk({6'h0, rx_fifo_reset_out, tx_fifo_reset_out}, 8'h00);
    rchk(3'h2, 8'hC1);
    host.wr(3'h2, 8'h0E);
    @(negedge core_clk_in);
    chk({6'h0, fifo_enable_out, dma_mode_out}, 8'h00);
    rchk(3'h2, 8'h01);
    host.wr(3'h2, 8'h01);
    $display("setup test done");
  endtask
  task t_tx;
    host.wr(3'h1, 8'h02);
    @(negedge core_clk_in);
    chk({7'h0, irq_out}, 8'h01);
    rchk(3'h2, 8'hC2);
    tx_load_in = 1;
    tx_level_in = 1;
    @(negedge core_clk_in);
    tx_load_in = 0;
    rchk(3'h2, 8'hC1);
    $display("transmit test done");
  endtask
  task t_prio;
    host.wr(3'h1, 8'h0F);
    rx_level_in = 1;
    rx_overrun_in = 1;
    modem_delta_in = 4'h1;
    rchk(3'h2, 8'hC6);
    rx_overrun_in = 0;
    host.rd(3'h5, d);
    rchk(3'h2, 8'hC4);
    rx_level_in = 0;
    rchk(3'h2, 8'hC0);
    modem_delta_in = 4'h0;
    host.rd(3'h6, d);
    rchk(3'h2, 8'hC1);
    $display("priority test done");
  endtask
  task t_timeout;
    host.wr(3'h1, 8'h01);
    rx_level_in = 1;
    rchk(3'h2, 8'hC4);
    repeat (90) @(negedge core_clk_in);
    rchk(3'h2, 8'hC4);
    repeat (14) @(negedge core_clk_in);
    rchk(3'h2, 8'hCC);
    rx_pop_in = 1;
    rx_level_in = 0;
    @(negedge core_clk_in);
    rx_pop_in = 0;
    rchk(3'h2, 8'hC1);
    $display("timeout test done");
  endtask
  task t_special;
    modem_control_in = 8'h84;
    host.wr(3'h1, 8'h20);
    @(negedge core_clk_in);
    chk({5'h0, special_mode_out, soft_reset_out, power_down_out}, 8'h07);
    rchk(3'h2, 8'hF1);
    host.wr(3'h2, 8'h19);
    @(negedge core_clk_in);
    chk({5'h0, dma_mode_out, tx_request_pin_out, rx_request_pin_out}, 8'h05);
    rchk(3'h2, 8'hE1);
    host.wr(3'h2, 8'h59);
    rx_level_in = 3;
    rchk(3'h2, 8'hE1);
    rx_level_in = 4;
    rchk(3'h2, 8'hC1);
    rx_level_in = 0;
    host.wr(3'h2, 8'h05);
    chk({6'h0, rx_fifo_reset_out, tx_fifo_reset_out}, 8'h01);
    host.wr(3'h1, 8'h00);
    @(negedge core_clk_in);
    chk({5'h0, special_mode_out, soft_reset_out, power_down_out}, 8'h00);
    modem_control_in = 8'h00;
    $display("special test done");
  endtask
  task t_line;
    host.wr(3'h1, 8'h04);
    tx_level_in = 0;
    tx_shifter_empty_in = 0;
    fifo_error_in = 1;
    head_error_in = 3'h2;
    rx_overrun_in = 1;
    rx_level_in = 1;
    @(negedge core_clk_in);
    chk(line_state_out, 8'hAB);
    rx_overrun_in = 0;
    rchk(3'h5, 8'hA9);
    rchk(3'h2, 8'hC1);
    rx_pop_in = 1;
    @(negedge core_clk_in);
    rx_pop_in = 0;
    rchk(3'h2, 8'hC6);
    rx_level_in = 0;
    head_error_in = 3'h0;
    fifo_error_in = 0;
    tx_shifter_empty_in = 1;
    host.rd(3'h5, d);
    rchk(3'h2, 8'hC1);
    $display("line test done");
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge core_clk_in);
    resetn_in = 1;
    t_setup;
    t_tx;
    t_prio;
    t_timeout;
    t_special;
    t_line;
    test_done;
  end
  initial
  begin
    #20000;
    miscompares++;
    test_done;
  end
endmodule // uifc_top_test
